// ===== rtl/scsi_init_defines.svh
`ifndef SCSI_INIT_DEFINES_SVH
`define SCSI_INIT_DEFINES_SVH

// Clock period of clk in ns (100 MHz)
`define SI_CLK_PERIOD_NS   10
// Bus reset hold time, least, in ns
`define SI_RST_HOLD_NS     25000
// Arbitration settle time, least, in ns
`define SI_ARB_DELAY_NS    2400
// Deskew and settle time for driven lines, least, in ns
`define SI_SETTLE_NS       400
// Selection timeout, longest, in ns
`define SI_SEL_TO_NS       250000

// Cycle counts: least times round up, the longest time rounds down
`define SI_RST_HOLD_CYC \
    ((`SI_RST_HOLD_NS + `SI_CLK_PERIOD_NS - 1) / `SI_CLK_PERIOD_NS)
`define SI_ARB_DELAY_CYC \
    ((`SI_ARB_DELAY_NS + `SI_CLK_PERIOD_NS - 1) / `SI_CLK_PERIOD_NS)
`define SI_SETTLE_CYC \
    ((`SI_SETTLE_NS + `SI_CLK_PERIOD_NS - 1) / `SI_CLK_PERIOD_NS)
`define SI_SEL_TO_CYC      (`SI_SEL_TO_NS / `SI_CLK_PERIOD_NS)

// Depth and width of the outbound byte buffer
`define SI_TX_DEPTH        8
`define SI_BYTE_W          8

`endif

// ===== rtl/scsi_init_pkg.sv
package scsi_init_pkg;

    // Bus identifier, one of eight data line positions
    typedef logic [2:0] id_t;

    // One byte on the data lines
    typedef logic [7:0] byte_t;

    // Bus phase as the target drives it
    typedef struct packed {
        logic msg;
        logic cd;
        logic io;
    } phase_t;

    // Initiator sequencer states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_FREE,
        ST_ARB,
        ST_SEL,
        ST_SEL_WAIT,
        ST_RESEL,
        ST_CONN,
        ST_IN_PUSH,
        ST_IN_ACK,
        ST_OUT_SETUP,
        ST_OUT_ACK,
        ST_RESET
    } state_t;

endpackage

// ===== rtl/fifo_if.sv
`timescale 1ns/10ps

// Valid/ready byte stream between the initiator's own modules
interface fifo_if #(
    parameter int W = 8
);
    logic         valid;   // Word offered
    logic         ready;   // Word can be taken
    logic [W-1:0] data;    // Offered word

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ===== rtl/byte_fifo.sv
`timescale 1ns/10ps

// Flop based FIFO; DEPTH must be a power of two so pointers wrap cleanly
module byte_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    fifo_if.snk      wr,
    fifo_if.src      rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [W-1:0]  mem_ff [DEPTH];   // Storage, indexed by pointer
    logic [AW-1:0] wp_ff;            // Write pointer
    logic [AW-1:0] rp_ff;            // Read pointer
    logic [AW:0]   cnt_ff;           // Words held
    logic          push;
    logic          pop;

    // Full and empty come straight from the count, so they never lie
    assign wr.ready = (cnt_ff != FULL);
    assign rd.valid = (cnt_ff != '0);
    assign rd.data  = mem_ff[rp_ff];
    assign push     = wr.valid & wr.ready;
    assign pop      = rd.valid & rd.ready;

    // Storage needs no reset; only counted words are ever read
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_ff[wp_ff] <= wr.data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop)
            begin
                rp_ff <= rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// ===== rtl/scsi_initiator.sv
// Function
// - Bus reset line stops everything, returns idle
// - Busy is wired-OR; asserted means occupied
// - Target drives control/data for control bytes
// - Target drives in/out for transfer direction
// - In/out tells selection from reselection
// - Target requests each byte separately
// - Target drops request only after acknowledge
// - Message line plus in/out gives message phase
// - Eight data lines plus odd parity line
// - Line 7 has highest arbitration priority
// - Parity ignored during arbitration
`timescale 1ns/10ps
`include "scsi_init_defines.svh"

module scsi_initiator #(
    parameter int SEL_TO_CYC = `SI_SEL_TO_CYC,
    parameter int TX_DEPTH   = `SI_TX_DEPTH
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire scsi_init_pkg::id_t   own_id,
    input  wire logic                 parity_en,
    input  wire logic                 sel_start,
    input  wire scsi_init_pkg::id_t   target_id,
    input  wire logic                 bus_reset_req,
    input  wire logic                 atn_req,
    input  wire logic                 tx_valid,
    output wire logic                 tx_ready,
    input  wire scsi_init_pkg::byte_t tx_data,
    output wire logic                 rx_valid,
    input  wire logic                 rx_ready,
    output wire scsi_init_pkg::byte_t rx_data,
    output wire logic                 busy,
    output wire logic                 connected,
    output wire scsi_init_pkg::phase_t phase,
    output wire logic                 sel_done,
    output wire logic                 sel_fail,
    output wire logic                 resel,
    output wire scsi_init_pkg::id_t   resel_id,
    output wire logic                 bus_free,
    output wire logic                 parity_err,
    input  wire logic [7:0]           db_n_i,
    output wire logic [7:0]           db_n_o,
    output wire logic [7:0]           db_oe,
    input  wire logic                 dbp_n_i,
    output wire logic                 dbp_n_o,
    output wire logic                 dbp_oe,
    input  wire logic                 bsy_n_i,
    output wire logic                 bsy_n_o,
    output wire logic                 bsy_oe,
    input  wire logic                 sel_n_i,
    output wire logic                 sel_n_o,
    output wire logic                 sel_oe,
    input  wire logic                 rst_n_i,
    output wire logic                 rst_n_o,
    output wire logic                 rst_oe,
    output wire logic                 atn_n_o,
    output wire logic                 ack_n_o,
    input  wire logic                 msg_n_i,
    input  wire logic                 cd_n_i,
    input  wire logic                 io_n_i,
    input  wire logic                 req_n_i
);
    import scsi_init_pkg::*;

    localparam logic [15:0] RST_CYC  = 16'(`SI_RST_HOLD_CYC);
    localparam logic [15:0] ARB_CYC  = 16'(`SI_ARB_DELAY_CYC);
    localparam logic [15:0] SET_CYC  = 16'(`SI_SETTLE_CYC);
    localparam logic [15:0] SELTO    = 16'(SEL_TO_CYC);

    state_t      state_ff;         // Sequencer state
    logic [15:0] timer_ff;         // Cycles spent in the current state
    logic [15:0] meta_ff;          // First synchroniser stage
    logic [15:0] sync_ff;          // Second synchroniser stage
    byte_t       rx_data_ff;       // Captured inbound byte
    byte_t       db_out_ff;        // Byte value driven to the lines
    logic [7:0]  db_oe_ff;         // Per line drive enables
    logic        dbp_oe_ff;        // Parity line drive enable
    logic        bsy_oe_ff;        // Our busy drive
    logic        sel_oe_ff;        // Our select drive
    logic        rst_oe_ff;        // Our reset drive
    logic        atn_ff;           // Attention condition
    logic        ack_ff;           // Acknowledge asserted
    logic        par_err_ff;       // Sticky parity error
    logic        sel_done_ff;      // Selection won pulse
    logic        sel_fail_ff;      // Selection lost or timed out pulse
    logic        resel_ff;         // Reselection accepted pulse
    id_t         resel_id_ff;      // Reselecting target
    logic        free_ff;          // Bus went free pulse
    phase_t      phase_ff;         // Latched phase of last request
    logic        timer_clr;        // Restart timer on state change

    // Decoded synchronised lines, active high inside the block
    byte_t  s_db;
    logic   s_dbp, s_bsy, s_sel, s_rst, s_msg, s_cd, s_io, s_req;
    byte_t  hi_mask;
    byte_t  s_resel_bits;
    logic   par_ok;
    phase_t s_phase;

    // Pins are active low; invert once here and nowhere else
    assign {s_rst, s_bsy, s_sel, s_msg, s_cd, s_io, s_req, s_dbp} =
        ~sync_ff[15:8];
    assign s_db    = ~sync_ff[7:0];
    assign s_phase = '{msg: s_msg, cd: s_cd, io: s_io};
    // Lines above our own ID outrank us; line 7 is the highest
    assign hi_mask = ~(8'hFF >> (3'd7 - own_id));
    // Odd parity over the nine lines
    assign par_ok  = ^{s_db, s_dbp};
    assign s_resel_bits = s_db & ~(8'h01 << own_id);

    // Every pin and status output but tx_ready
    assign db_n_o    = ~db_out_ff;
    assign db_oe     = db_oe_ff;
    assign dbp_n_o   = ^db_out_ff;
    assign dbp_oe    = dbp_oe_ff;
    assign bsy_n_o   = 1'b0;        // Open collector: only pull low
    assign bsy_oe    = bsy_oe_ff;
    assign sel_n_o   = 1'b0;
    assign sel_oe    = sel_oe_ff;
    assign rst_n_o   = 1'b0;
    assign rst_oe    = rst_oe_ff;
    assign atn_n_o   = ~atn_ff;
    assign ack_n_o   = ~ack_ff;
    assign rx_data   = rx_data_ff;
    assign rx_valid  = (state_ff == ST_IN_PUSH);
    assign busy      = (state_ff != ST_IDLE);
    assign connected = (state_ff >= ST_RESEL) && (state_ff != ST_RESET);
    assign phase     = phase_ff;
    assign sel_done  = sel_done_ff;
    assign sel_fail  = sel_fail_ff;
    assign resel     = resel_ff;
    assign resel_id  = resel_id_ff;
    assign bus_free  = free_ff;
    assign parity_err = par_err_ff;

    // Outbound bytes pass an 8 word buffer; a full buffer stalls the user
    fifo_if #(.W(`SI_BYTE_W)) tx_w ();
    fifo_if #(.W(`SI_BYTE_W)) tx_r ();
    assign tx_w.valid = tx_valid;
    assign tx_w.data  = tx_data;
    assign tx_ready   = tx_w.ready;
    assign tx_r.ready = (state_ff == ST_CONN) && s_req && !s_io && s_bsy;

    byte_fifo #(.W(`SI_BYTE_W), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .clk (clk),
        .rst (rst),
        .wr  (tx_w),
        .rd  (tx_r)
    );

    // Two stage synchroniser for every line from the cable
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff <= 16'hFFFF;
            sync_ff <= 16'hFFFF;
        end
        else
        begin
            meta_ff <= {rst_n_i, bsy_n_i, sel_n_i, msg_n_i, cd_n_i, io_n_i,
                        req_n_i, dbp_n_i, db_n_i};
            sync_ff <= meta_ff;
        end
    end

    // Attention follows the user request, dropped while the bus resets
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            atn_ff <= 1'b0;
        end
        else
        begin
            atn_ff <= atn_req && !s_rst && !rst_oe_ff;
        end
    end

    // State timer; it clears one cycle after a move, so every compare
    // also waits for timer_clr to fall rather than read a stale count
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            timer_ff <= 16'h0000;
        end
        else if (timer_clr)
        begin
            timer_ff <= 16'h0000;
        end
        else if (timer_ff != 16'hFFFF)
        begin
            timer_ff <= timer_ff + 16'h0001;
        end
    end

    // Sequencer and all bus drives but attention
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff    <= ST_IDLE;
            timer_clr   <= 1'b1;
            db_out_ff   <= 8'h00;
            db_oe_ff    <= 8'h00;
            dbp_oe_ff   <= 1'b0;
            bsy_oe_ff   <= 1'b0;
            sel_oe_ff   <= 1'b0;
            rst_oe_ff   <= 1'b0;
            ack_ff      <= 1'b0;
            rx_data_ff  <= 8'h00;
            par_err_ff  <= 1'b0;
            sel_done_ff <= 1'b0;
            sel_fail_ff <= 1'b0;
            resel_ff    <= 1'b0;
            resel_id_ff <= 3'h0;
            free_ff     <= 1'b0;
            phase_ff    <= '0;
        end
        else
        begin
            timer_clr   <= 1'b0;
            sel_done_ff <= 1'b0;
            sel_fail_ff <= 1'b0;
            resel_ff    <= 1'b0;
            free_ff     <= 1'b0;
            if (s_rst && state_ff != ST_RESET)
            begin
                // Someone resets the bus: drop every drive at once
                state_ff  <= ST_IDLE;
                timer_clr <= 1'b1;
                db_oe_ff  <= 8'h00;
                dbp_oe_ff <= 1'b0;
                bsy_oe_ff <= 1'b0;
                sel_oe_ff <= 1'b0;
                ack_ff    <= 1'b0;
            end
            else
            begin
                case (state_ff)
                    ST_IDLE:
                    begin
                        if (bus_reset_req)
                        begin
                            rst_oe_ff <= 1'b1;
                            state_ff  <= ST_RESET;
                            timer_clr <= 1'b1;
                        end
                        else if (s_sel && s_io && !s_bsy &&
                                 s_db[own_id] && s_resel_bits != 8'h00)
                        begin
                            // In/out set with select: a reselection
                            bsy_oe_ff <= 1'b1;
                            for (int i = 0; i < 8; i++)
                            begin
                                if (s_resel_bits[i])
                                begin
                                    resel_id_ff <= 3'(i);
                                end
                            end
                            state_ff <= ST_RESEL;
                        end
                        else if (sel_start)
                        begin
                            par_err_ff <= 1'b0;
                            state_ff   <= ST_FREE;
                            timer_clr  <= 1'b1;
                        end
                    end
                    ST_FREE:
                    begin
                        // Busy or select seen restarts the free wait
                        if (s_bsy || s_sel)
                        begin
                            timer_clr <= 1'b1;
                        end
                        else if (!timer_clr && timer_ff >= SET_CYC)
                        begin
                            bsy_oe_ff <= 1'b1;
                            db_out_ff <= 8'h01 << own_id;
                            db_oe_ff  <= 8'h01 << own_id;
                            dbp_oe_ff <= 1'b0;
                            state_ff  <= ST_ARB;
                            timer_clr <= 1'b1;
                        end
                    end
                    ST_ARB:
                    begin
                        // Parity line is not looked at here
                        if (!timer_clr && timer_ff >= ARB_CYC)
                        begin
                            timer_clr <= 1'b1;
                            if ((s_db & hi_mask) != 8'h00 || s_sel)
                            begin
                                bsy_oe_ff   <= 1'b0;
                                db_oe_ff    <= 8'h00;
                                sel_fail_ff <= 1'b1;
                                state_ff    <= ST_IDLE;
                            end
                            else
                            begin
                                sel_oe_ff <= 1'b1;
                                state_ff  <= ST_SEL;
                            end
                        end
                    end
                    ST_SEL:
                    begin
                        // Put both ID bits up, then let our busy go
                        db_out_ff <= (8'h01 << own_id) | (8'h01 << target_id);
                        db_oe_ff  <= 8'hFF;
                        dbp_oe_ff <= 1'b1;
                        if (!timer_clr && timer_ff >= SET_CYC)
                        begin
                            bsy_oe_ff <= 1'b0;
                            state_ff  <= ST_SEL_WAIT;
                            timer_clr <= 1'b1;
                        end
                    end
                    ST_SEL_WAIT:
                    begin
                        // Wait out our own busy echo before trusting it
                        if (!timer_clr && timer_ff >= SET_CYC && s_bsy)
                        begin
                            sel_oe_ff   <= 1'b0;
                            db_oe_ff    <= 8'h00;
                            dbp_oe_ff   <= 1'b0;
                            sel_done_ff <= 1'b1;
                            state_ff    <= ST_CONN;
                        end
                        else if (!timer_clr && timer_ff >= SELTO)
                        begin
                            sel_oe_ff   <= 1'b0;
                            db_oe_ff    <= 8'h00;
                            dbp_oe_ff   <= 1'b0;
                            sel_fail_ff <= 1'b1;
                            state_ff    <= ST_IDLE;
                        end
                    end
                    ST_RESEL:
                    begin
                        // Target holds busy and drops select: hand over
                        if (!s_sel)
                        begin
                            bsy_oe_ff <= 1'b0;
                            resel_ff  <= 1'b1;
                            state_ff  <= ST_CONN;
                        end
                    end
                    ST_CONN:
                    begin
                        if (!s_bsy)
                        begin
                            free_ff  <= 1'b1;
                            state_ff <= ST_IDLE;
                        end
                        else if (s_req && s_io)
                        begin
                            // One request carries one inbound byte
                            phase_ff   <= s_phase;
                            rx_data_ff <= s_db;
                            if (parity_en && !par_ok)
                            begin
                                par_err_ff <= 1'b1;
                            end
                            state_ff <= ST_IN_PUSH;
                        end
                        else if (s_req && tx_r.valid)
                        begin
                            phase_ff  <= s_phase;
                            db_out_ff <= tx_r.data;
                            db_oe_ff  <= 8'hFF;
                            dbp_oe_ff <= 1'b1;
                            state_ff  <= ST_OUT_SETUP;
                            timer_clr <= 1'b1;
                        end
                    end
                    ST_IN_PUSH:
                    begin
                        // Byte is only acknowledged once the user took it
                        if (rx_ready)
                        begin
                            ack_ff   <= 1'b1;
                            state_ff <= ST_IN_ACK;
                        end
                    end
                    ST_OUT_SETUP:
                    begin
                        // Data must settle on the cable before acknowledge
                        if (!timer_clr && timer_ff >= SET_CYC)
                        begin
                            ack_ff   <= 1'b1;
                            state_ff <= ST_OUT_ACK;
                        end
                    end
                    ST_IN_ACK,
                    ST_OUT_ACK:
                    begin
                        // Target drops request only after our acknowledge
                        if (!s_req)
                        begin
                            ack_ff    <= 1'b0;
                            db_oe_ff  <= 8'h00;
                            dbp_oe_ff <= 1'b0;
                            state_ff  <= ST_CONN;
                        end
                    end
                    ST_RESET:
                    begin
                        if (!timer_clr && timer_ff >= RST_CYC)
                        begin
                            rst_oe_ff <= 1'b0;
                            state_ff  <= ST_IDLE;
                        end
                    end
                    default:
                    begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// ===== test/scsi_init_chk.sv
`timescale 1ns/10ps

// Watches the initiator's pins for order and encoding slips
module scsi_init_chk (
    input wire logic clk, rst, sel_oe, bsy_oe, dbp_oe, dbp_n_o, ack_n_o,
    input wire logic atn_n_o, atn_req, req_n_i, bsy_n_i, rst_n_i, connected,
    input wire logic [7:0] db_oe, db_n_o,
    input wire scsi_init_pkg::id_t own_id, target_id
);
    import scsi_init_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_sel_ids; sel_oe && $past(sel_oe) |->
        db_n_o == ~(8'h01 << own_id | 8'h01 << target_id); endproperty
    a_sel_ids: assert property (p_sel_ids) else $error("sel ids");
    property p_sel_rel;
        $fell(bsy_oe) && sel_oe && !bsy_n_i |-> ##[1:60] !sel_oe; endproperty
    a_sel_rel: assert property (p_sel_rel) else $error("sel held");
    property p_ack_req; $fell(ack_n_o) |-> !req_n_i; endproperty
    a_ack_req: assert property (p_ack_req) else $error("ack req");
    // Release only once the request has been gone for two samples
    property p_ack_rel;
        $rose(ack_n_o) && rst_n_i |-> req_n_i && $past(req_n_i); endproperty
    a_ack_rel: assert property (p_ack_rel) else $error("ack rel");
    property p_par; dbp_oe |-> dbp_n_o == ^db_n_o; endproperty
    a_par: assert property (p_par) else $error("parity");
    property p_arb; bsy_oe && !sel_oe && !connected |->
        db_oe == 8'h01 << own_id && !dbp_oe; endproperty
    a_arb: assert property (p_arb) else $error("arb");
    property p_atn; 1'b1 |=> atn_n_o == !$past(atn_req); endproperty
    a_atn: assert property (p_atn) else $error("attention");
    property p_bus_rst; !rst_n_i [*6] |->
        !bsy_oe && !sel_oe && db_oe == 8'h00 && ack_n_o; endproperty
    a_bus_rst: assert property (p_bus_rst) else $error("bus reset");
endmodule

bind scsi_initiator scsi_init_chk u_chk (.clk, .rst, .sel_oe, .bsy_oe,
    .dbp_oe, .dbp_n_o, .ack_n_o, .atn_n_o, .atn_req, .req_n_i, .bsy_n_i,
    .rst_n_i, .connected, .db_oe, .db_n_o, .own_id, .target_id);

// ===== test/scsi_target_model.sv
`timescale 1ns/10ps

// Behavioural target: answers selection, one request per byte
module scsi_target_model #(parameter logic [2:0] TID = 3'h2) (
    input  wire logic       clk, answer, sel_n, rst_n, ack_n,
    input  wire logic [7:0] db_n,
    output logic            bsy, db_en, dbp_o, req_n, io_n, cd_n, msg_n,
    output logic [7:0]      db_o
);
    initial {bsy, db_en, dbp_o, req_n, io_n, cd_n, msg_n, db_o} = 15'h1FFF;
    // Busy joins the wired line once our bit is seen with select
    always @(posedge clk)
        if (!rst_n || !answer)
            bsy <= 1'b0;
        else if (!sel_n && !db_n[TID])
            bsy <= 1'b1;
    // Gap sets how slowly the request follows the phase lines
    task automatic xfer(input logic [2:0] ph, input logic [7:0] d,
                        input logic bad, input int gap, output logic [7:0] got);
        @(posedge clk);
        {msg_n, cd_n, io_n} <= ~ph;
        db_en <= ph[0];
        db_o <= ~d;
        dbp_o <= ^d ^ bad;
        repeat (gap) @(posedge clk);
        req_n <= 1'b0;
        while (ack_n) @(posedge clk);
        got = ~db_n;
        req_n <= 1'b1;
        while (!ack_n) @(posedge clk);
        db_en <= 1'b0;
    endtask
endmodule

// ===== test/tb.sv
`timescale 1ns/10ps
`include "scsi_init_defines.svh"

module tb;
    import scsi_init_pkg::*;
    logic  clk = 1'b0, rst = 1'b1, answer = 1'b0, rx_ready = 1'b1;
    logic  sel_start = 1'b0, bus_reset_req = 1'b0, atn_req = 1'b0;
    logic  parity_en = 1'b1, tx_valid = 1'b0;
    byte_t tx_data = 8'h00;
    id_t   own_id = 3'h7, target_id = 3'h2;
    wire logic tx_ready, busy, connected, sel_done, sel_fail, bus_free;
    wire logic parity_err, dbp_n_o, dbp_oe, bsy_oe, sel_oe, rst_oe, atn_n_o;
    wire logic ack_n_o, t_bsy, t_en, t_dbp, msg_n_i, cd_n_i, io_n_i, req_n_i;
    wire byte_t rx_data, db_n_o, db_oe, t_db;
    wire phase_t phase;
    // Open lines: any driver pulls low, terminators pull high
    wire byte_t db_n_i = (db_n_o | ~db_oe) & (t_en ? t_db : 8'hFF);
    wire logic dbp_n_i = (dbp_n_o | ~dbp_oe) & (t_en ? t_dbp : 1'b1);
    wire logic bsy_n_i = ~(bsy_oe | t_bsy);
    wire logic sel_n_i = ~sel_oe;
    wire logic rst_n_i = ~rst_oe;
    int n_errors = 0, checks = 0, cyc = 0;
    scsi_initiator #(.SEL_TO_CYC(200)) i_dut (.*, .rx_valid(), .resel(),
        .resel_id(), .bsy_n_o(), .sel_n_o(), .rst_n_o());
    scsi_target_model #(.TID(3'h2)) u_tgt (.clk, .answer, .sel_n(sel_n_i),
        .rst_n(rst_n_i), .ack_n(ack_n_o), .db_n(db_n_i), .bsy(t_bsy),
        .db_o(t_db), .db_en(t_en), .dbp_o(t_dbp), .req_n(req_n_i),
        .io_n(io_n_i), .cd_n(cd_n_i), .msg_n(msg_n_i));
    initial forever #5 clk = ~clk;
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e)
        begin
            $display("FAIL %s exp %h got %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Our own bus reset must be held at least its minimum time
    task automatic t_bus_reset;
        int n = 0;
        @(posedge clk) bus_reset_req <= 1'b1;
        @(posedge clk) bus_reset_req <= 1'b0;
        repeat (3000) @(negedge clk) n += rst_oe;
        chk("rst_hold", 16'h1, 16'(n >= `SI_RST_HOLD_CYC));
        chk("rst_end", 16'h0, 16'(rst_oe));
    endtask
    // Selection with a silent or an answering target
    task automatic t_sel(input logic ans);
        int k;
        @(posedge clk) answer <= ans;
        @(posedge clk) sel_start <= 1'b1;
        @(posedge clk) sel_start <= 1'b0;
        for (k = 0; k < 2000 && !(sel_done | sel_fail); k++) @(negedge clk);
        chk("sel_ok", 16'(ans), 16'(sel_done & connected));
        chk("sel_fail", 16'(!ans), 16'(sel_fail));
    endtask
    // Fill the buffer until it refuses, then drain it, slow and prompt
    task automatic t_out;
        phase_t ph[3] = '{3'b000, 3'b010, 3'b110};
        byte_t  got;
        for (int i = 0; i < 8; i++)
            @(posedge clk) {tx_valid, tx_data} <= {1'b1, 8'(8'h13 * i)};
        @(posedge clk) {tx_valid, atn_req} <= 2'b01;
        @(negedge clk) chk("tx_ready", 16'h0, 16'(tx_ready));
        @(negedge clk) chk("atn", 16'h0, 16'(atn_n_o));
        for (int i = 0; i < 8; i++)
        begin
            u_tgt.xfer(ph[i % 3], 8'h00, 1'b0, 2 + 20 * (i % 2), got);
            chk("out_byte", 16'(8'h13 * i), 16'(got));
            chk("out_phase", 16'(ph[i % 3]), 16'(phase));
        end
        atn_req <= 1'b0;
        @(negedge clk) chk("tx_ready", 16'h1, 16'(tx_ready));
    endtask
    // Inbound bytes; the last two carry a parity fault, but checking is
    // off for the middle one, so only the third may raise the error
    task automatic t_in;
        phase_t ph[3] = '{3'b001, 3'b011, 3'b111};
        byte_t  got;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk) parity_en <= i != 1;
            u_tgt.xfer(ph[i], 8'hC3 ^ 8'(i), i > 0, 2 + 20 * i, got);
            @(negedge clk);
            chk("in_byte", 16'(8'hC3 ^ 8'(i)), 16'(rx_data));
            chk("in_phase", 16'(ph[i]), 16'(phase));
            chk("par_err", 16'(i > 1), 16'(parity_err));
        end
    endtask
    // Target lets go of busy; the bus must read as free
    task automatic t_free;
        int k;
        @(posedge clk) answer <= 1'b0;
        for (k = 0; k < 100 && bus_free !== 1'b1; k++) @(negedge clk);
        chk("bus_free", 16'h1, 16'(bus_free));
        chk("busy", 16'h0, 16'(busy));
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_bus_reset();
        t_sel(1'b0);
        t_sel(1'b1);
        t_out();
        t_in();
        t_free();
        wrap_up();
    end
    // Cuts a hang short
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_errors++;
            wrap_up();
        end
    end
endmodule
